//--- lms_ctrl_model.sv
// controller model driving the dual-edge serial link
`timescale 1ns/1ns
`default_nettype none
module lms_ctrl_model (
   // serial link
   output var logic sclk_o,
   output var logic sdat_o
);
   initial begin
      sclk_o = 1'b0;
      sdat_o = 1'b1;
   end
   // bit on each edge
   // data moves mid-half so both edges see it settled; clock halts between words
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         sdat_o = w[i];
         #40;
         sclk_o = ~sclk_o;
         #40;
      end
      sdat_o = ~w[0];
   endtask
endmodule
`default_nettype wire

//--- lms_map.vh
// register map, field positions, reset values and timing counts for the led matrix scan block
// Functional notes
// - 3-bit stack code selects eight modes
// - independent mode scans own 16 switches
// - stacked switches serve all devices' columns
// - 32x32 stack: D1 lines 1-16, D2 17-32
// - second device rotated, switch mapping reversed
// - reverse bit steps switches in reverse
// - stacked device stores its own section pair
// - serial data taken on both clock edges
// - grayscale clock derived from serial clock
// - brightness code and color gains scale current
// - open, weak-short, short faults made readable
`ifndef LMS_MAP_VH
`define LMS_MAP_VH
// register byte offsets
`define LMS_REG_CTRL     6'h00
`define LMS_REG_LINES    6'h04
`define LMS_REG_BRIGHT   6'h08
`define LMS_REG_GAIN     6'h0c
`define LMS_REG_STATUS   6'h10
`define LMS_REG_CLEAR    6'h14
`define LMS_REG_IRQEN    6'h18
`define LMS_REG_SCAN     6'h1c
`define LMS_REG_RXWORD   6'h20
// control field positions
`define LMS_CTRL_RUN     0
`define LMS_CTRL_MODE_LO 1
`define LMS_CTRL_MODE_HI 3
`define LMS_CTRL_REV     4
`define LMS_CTRL_POS_LO  5
`define LMS_CTRL_POS_HI  6
// status bits
`define LMS_ST_WORD      0
`define LMS_ST_FRAME     1
`define LMS_ST_OPEN      2
`define LMS_ST_WSHORT    3
`define LMS_ST_SHORT     4
`define LMS_ST_W         5
// reset values
`define LMS_RST_CTRL     7'h00
`define LMS_RST_LINES    5'h10
`define LMS_RST_BRIGHT   3'h3
`define LMS_RST_GAIN     8'h7f
// timing: grayscale ticks per scan segment
`define LMS_SEG_TICKS    256
`endif

//--- lms_scan.v
// led matrix scan sequencer with stacking, serial capture, gains, faults and register port
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "lms_map.vh"
module lms_scan #(
   parameter SEG_TICKS = `LMS_SEG_TICKS,
   parameter WORD_BITS = 16
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // register port
   input  wire [5:0]  addr_i,
   input  wire [31:0] wr_data_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rd_data_o,
   // serial link
   input  wire        serial_clk_i,
   input  wire        serial_data_in_i,
   output reg         serial_data_out_o,
   // led fault comparators
   input  wire        led_open_i,
   input  wire        led_wshort_i,
   input  wire        led_short_i,
   // scan and current outputs
   output reg  [15:0] line_enable_o,
   output reg  [3:0]  line_switch_index_o,
   output reg  [5:0]  display_row_o,
   output reg         grayscale_clock_o,
   output reg  [11:0] current_red_o,
   output reg  [11:0] current_green_o,
   output reg  [11:0] current_blue_o,
   // interrupt
   output reg         irq_o
);

   localparam ST_IDLE   = 3'b001;
   localparam ST_SCAN   = 3'b010;
   localparam ST_SWITCH = 3'b100;

   ////////////////////////////////////////////////////////////////////////////////
   // mode tables

   // number of scanning devices per stack code
   function [2:0] dev_count;
      input [2:0] mode;
      begin
         case (mode)
            3'h0:    dev_count = 3'h1;
            3'h1:    dev_count = 3'h2;
            3'h6:    dev_count = 3'h4;
            3'h7:    dev_count = 3'h4;
            default: dev_count = 3'h3;
         endcase
      end
   endfunction

   // device owning the switches at a given step of the sequence
   function [1:0] dev_order;
      input [2:0] mode;
      input [1:0] step;
      begin
         case ({mode, step})
            5'b011_01: dev_order = 2'h2;
            5'b011_10: dev_order = 2'h1;
            5'b101_01: dev_order = 2'h2;
            5'b101_10: dev_order = 2'h1;
            5'b111_01: dev_order = 2'h3;
            5'b111_10: dev_order = 2'h1;
            5'b111_11: dev_order = 2'h2;
            default:   dev_order = step;
         endcase
      end
   endfunction

   // current code: (1 + color gain) scaled by (1 + global code)
   function [11:0] scale;
      input [7:0] gain;
      input [2:0] code;
      reg   [12:0] prod;
      begin
         prod  = ({5'h00, gain} + 13'h0001) * ({10'h000, code} + 13'h0001);
         scale = prod[11:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   reg [6:0]               ctrl;
   reg [4:0]               lines_used;
   reg [2:0]               global_brightness_code;
   reg [7:0]               red_group_gain;
   reg [7:0]               green_group_gain;
   reg [7:0]               blue_group_gain;
   reg [`LMS_ST_W-1:0]     status;
   reg [`LMS_ST_W-1:0]     irq_en;
   reg [WORD_BITS-1:0]     rx_word;
   reg [5:0]               fault_row;
   reg [`LMS_ST_W-1:0]     events;

   wire [2:0] stack_size_select  = ctrl[`LMS_CTRL_MODE_HI:`LMS_CTRL_MODE_LO];
   wire       scan_order_reverse = ctrl[`LMS_CTRL_REV];
   wire [1:0] stack_pos          = ctrl[`LMS_CTRL_POS_HI:`LMS_CTRL_POS_LO];
   wire       run                = ctrl[`LMS_CTRL_RUN];
   wire       wr_clear           = wr_i && (addr_i == `LMS_REG_CLEAR);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   reg sclk_s1, sclk_s2, sclk_s3;
   reg sdi_s1, sdi_s2;
   reg [2:0] flt_s1, flt_s2, flt_s3;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         sdi_s1  <= 1'b0;
         sdi_s2  <= 1'b0;
         flt_s1  <= 3'h0;
         flt_s2  <= 3'h0;
         flt_s3  <= 3'h0;
      end else begin
         sclk_s1 <= serial_clk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sdi_s1  <= serial_data_in_i;
         sdi_s2  <= sdi_s1;
         flt_s1  <= {led_short_i, led_wshort_i, led_open_i};
         flt_s2  <= flt_s1;
         flt_s3  <= flt_s2;
      end
   end

   wire sclk_edge = sclk_s2 ^ sclk_s3;
   wire [2:0] flt_rise = flt_s2 & ~flt_s3;

   ////////////////////////////////////////////////////////////////////////////////
   // serial capture and grayscale tick

   reg [WORD_BITS-1:0] shift;
   reg [4:0]           bit_cnt;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift             <= {WORD_BITS{1'b0}};
         bit_cnt           <= 5'h00;
         rx_word           <= {WORD_BITS{1'b0}};
         serial_data_out_o <= 1'b0;
         grayscale_clock_o <= 1'b0;
      end else begin
         grayscale_clock_o <= sclk_edge;
         if (!run) begin
            bit_cnt <= 5'h00;
         end else if (sclk_edge) begin
            shift             <= {shift[WORD_BITS-2:0], sdi_s2};
            serial_data_out_o <= shift[WORD_BITS-1];
            if (bit_cnt == WORD_BITS - 1) begin
               bit_cnt <= 5'h00;
               rx_word <= {shift[WORD_BITS-2:0], sdi_s2};
            end else begin
               bit_cnt <= bit_cnt + 5'h01;
            end
         end
      end
   end

   wire word_done = run && sclk_edge && (bit_cnt == WORD_BITS - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // scan sequencer

   reg [2:0]  state;
   reg [15:0] seg_cnt;
   reg [1:0]  step;
   reg [3:0]  line;
   reg        frame_done;

   // stack code sets length and order
   wire [2:0] ndev      = dev_count(stack_size_select);
   wire [1:0] owner     = dev_order(stack_size_select, step);
   wire       mine      = (stack_size_select == 3'h0) || (owner == stack_pos);
   wire [3:0] sw_idx    = scan_order_reverse ? (4'hf - line) : line;
   wire       line_live = ({1'b0, line} < lines_used);
   wire       seg_end   = grayscale_clock_o && (seg_cnt == SEG_TICKS - 1);
   wire       last_step = ({1'b0, step} == ndev - 3'h1);

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state               <= ST_IDLE;
         seg_cnt             <= 16'h0000;
         step                <= 2'h0;
         line                <= 4'h0;
         frame_done          <= 1'b0;
         line_enable_o       <= 16'h0000;
         line_switch_index_o <= 4'h0;
         display_row_o       <= 6'h00;
      end else begin
         frame_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               line_enable_o <= 16'h0000;
               seg_cnt       <= 16'h0000;
               step          <= 2'h0;
               line          <= 4'h0;
               if (run) begin
                  state <= ST_SWITCH;
               end
            end
            ST_SCAN: begin
               if (!run) begin
                  state <= ST_IDLE;
               end else if (seg_end) begin
                  line_enable_o <= 16'h0000;
                  seg_cnt       <= 16'h0000;
                  state         <= ST_SWITCH;
                  line          <= line + 4'h1;
                  if (line == 4'hf) begin
                     step       <= last_step ? 2'h0 : step + 2'h1;
                     frame_done <= last_step;
                  end
               end else if (grayscale_clock_o) begin
                  seg_cnt <= seg_cnt + 16'h0001;
               end
            end
            ST_SWITCH: begin
               if (!run) begin
                  state <= ST_IDLE;
               end else if (grayscale_clock_o) begin
                  state               <= ST_SCAN;
                  line_enable_o       <= (mine && line_live) ? (16'h0001 << sw_idx) : 16'h0000;
                  line_switch_index_o <= sw_idx;
                  display_row_o       <= {step, line};
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // faults, events and current codes

   always @* begin
      events                  = {`LMS_ST_W{1'b0}};
      events[`LMS_ST_WORD]    = word_done;
      events[`LMS_ST_FRAME]   = frame_done;
      // faults only while a line is lit
      events[`LMS_ST_OPEN]    = flt_rise[0] && (line_enable_o != 16'h0000);
      events[`LMS_ST_WSHORT]  = flt_rise[1] && (line_enable_o != 16'h0000);
      events[`LMS_ST_SHORT]   = flt_rise[2] && (line_enable_o != 16'h0000);
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status          <= {`LMS_ST_W{1'b0}};
         fault_row       <= 6'h00;
         irq_o           <= 1'b0;
         current_red_o   <= 12'h000;
         current_green_o <= 12'h000;
         current_blue_o  <= 12'h000;
      end else begin
         // new events win over a clear in the same cycle
         status <= (status & ~(wr_clear ? wr_data_i[`LMS_ST_W-1:0] : {`LMS_ST_W{1'b0}})) | events;
         if (|events[`LMS_ST_SHORT:`LMS_ST_OPEN]) begin
            fault_row <= display_row_o;
         end
         irq_o           <= |(status & irq_en);
         current_red_o   <= scale(red_group_gain, global_brightness_code);
         current_green_o <= scale(green_group_gain, global_brightness_code);
         current_blue_o  <= scale(blue_group_gain, global_brightness_code);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl                   <= `LMS_RST_CTRL;
         lines_used             <= `LMS_RST_LINES;
         global_brightness_code <= `LMS_RST_BRIGHT;
         red_group_gain         <= `LMS_RST_GAIN;
         green_group_gain       <= `LMS_RST_GAIN;
         blue_group_gain        <= `LMS_RST_GAIN;
         irq_en                 <= {`LMS_ST_W{1'b0}};
         rd_data_o              <= 32'h00000000;
      end else begin
         if (wr_i) begin
            case (addr_i)
               `LMS_REG_CTRL:   ctrl <= wr_data_i[6:0];
               `LMS_REG_LINES:  lines_used <= (wr_data_i[4:0] > 5'h10) ? 5'h10 : wr_data_i[4:0];
               `LMS_REG_BRIGHT: global_brightness_code <= wr_data_i[2:0];
               `LMS_REG_GAIN: begin
                  red_group_gain   <= wr_data_i[7:0];
                  green_group_gain <= wr_data_i[15:8];
                  blue_group_gain  <= wr_data_i[23:16];
               end
               `LMS_REG_IRQEN:  irq_en <= wr_data_i[`LMS_ST_W-1:0];
               default: begin
               end
            endcase
         end
         rd_data_o <= 32'h00000000;
         if (rd_i) begin
            case (addr_i)
               `LMS_REG_CTRL:   rd_data_o <= {25'h0000000, ctrl};
               `LMS_REG_LINES:  rd_data_o <= {27'h0000000, lines_used};
               `LMS_REG_BRIGHT: rd_data_o <= {29'h00000000, global_brightness_code};
               `LMS_REG_GAIN:   rd_data_o <= {8'h00, blue_group_gain, green_group_gain, red_group_gain};
               `LMS_REG_STATUS: rd_data_o <= {27'h0000000, status};
               `LMS_REG_IRQEN:  rd_data_o <= {27'h0000000, irq_en};
               `LMS_REG_SCAN:   rd_data_o <= {12'h000, fault_row, display_row_o, line_switch_index_o,
                                              |line_enable_o, state};
               `LMS_REG_RXWORD: rd_data_o <= {{(32-WORD_BITS){1'b0}}, rx_word};
               default:         rd_data_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

//--- lms_scan_assertions.sv
// checker for scan, link tick, current and read port behaviour
`timescale 1ns/1ns
`default_nettype none
module lms_scan_assertions (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // register port
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rd_data_o,
   // link, scan and current outputs
   input wire logic        serial_data_out_o,
   input wire logic [15:0] line_enable_o,
   input wire logic [3:0]  line_switch_index_o,
   input wire logic [5:0]  display_row_o,
   input wire logic        grayscale_clock_o,
   input wire logic [11:0] current_red_o
);
   logic [1:0] up_cnt;
   // outputs settle from reset values during the first edges
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         up_cnt <= 2'h0;
      else if (up_cnt != 2'h3)
         up_cnt <= up_cnt + 2'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_ONE_LINE: assert property ($onehot0(line_enable_o))
      else $error("more than one line switch on");
   AST_LINE_IDX: assert property (line_enable_o != 16'h0 |-> line_enable_o == (16'h1 << line_switch_index_o))
      else $error("enabled switch differs from index");
   AST_ROW_IDX: assert property (line_enable_o != 16'h0 |-> line_switch_index_o == display_row_o[3:0]
      || line_switch_index_o == 4'hf - display_row_o[3:0])
      else $error("switch index not row line or its reverse");
   AST_GS_PULSE: assert property (grayscale_clock_o |=> !grayscale_clock_o [*2])
      else $error("grayscale tick too long or too close");
   AST_LINE_STEP: assert property (up_cnt == 2'h3 && $changed(line_enable_o) |-> grayscale_clock_o
      || $past(grayscale_clock_o) || $past(grayscale_clock_o, 2) || $past(wr_i) || $past(wr_i, 2)
      || $past(wr_i, 3))
      else $error("line changed without tick or write");
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
      else $error("read data outside read cycle");
   AST_CUR_HOLD: assert property (up_cnt == 2'h3 && !$past(wr_i) && !$past(wr_i, 2) |-> $stable(current_red_o))
      else $error("current changed without write");
   AST_SERIAL_OUT_TICK: assert property (up_cnt == 2'h3 && $changed(serial_data_out_o)
      |-> grayscale_clock_o || $past(grayscale_clock_o))
      else $error("serial out moved without edge");
   cover property (line_enable_o != 16'h0);
   cover property (grayscale_clock_o);
   cover property (rd_i ##1 rd_data_o != 32'h0);
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the led matrix scan block
`timescale 1ns/1ns
`default_nettype none
`include "lms_map.vh"
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [5:0]  addr_i = 6'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [2:0]  flt = 3'h0;
   wire  [31:0] rd_data_o;
   wire         sclk, sdat, sdo, gs, irq_o;
   wire  [15:0] en;
   wire  [3:0]  idx;
   wire  [11:0] cur_r, cur_g, cur_b;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          gs_cnt = 0;
   int          gs_base = 0;
   logic [15:0] sw_seen = 16'h0;
   logic        hit;
   logic [31:0] rd_val;
   logic [15:0] en_seen, word;
   logic [3:0]  idx_seen;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (gs === 1'b1)
         gs_cnt <= gs_cnt + 1;
      // switches lit since the last control write
      if (wr_i && addr_i == `LMS_REG_CTRL)
         sw_seen <= 16'h0;
      else
         sw_seen <= sw_seen | en;
   end
   lms_ctrl_model ctrl (.sclk_o(sclk), .sdat_o(sdat));
   lms_scan #(.SEG_TICKS(4)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .serial_clk_i(sclk), .serial_data_in_i(sdat),
      .serial_data_out_o(sdo), .led_open_i(flt[0]), .led_wshort_i(flt[1]), .led_short_i(flt[2]),
      .line_enable_o(en), .line_switch_index_o(idx), .display_row_o(), .grayscale_clock_o(gs),
      .current_red_o(cur_r), .current_green_o(cur_g), .current_blue_o(cur_b), .irq_o(irq_o));
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] e, input string w);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rd_val = rd_data_o;
      chk(w, e, rd_val);
   endtask
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rchk(`LMS_REG_CTRL, 32'h0, "ctrl");
      rchk(`LMS_REG_GAIN, 32'h7f7f7f, "gain");
      rchk(`LMS_REG_BRIGHT, 32'h3, "bright");
      rchk(6'h3c, 32'h0, "unmapped");
      chk("red", 32'd512, {20'h0, cur_r});
      wr(`LMS_REG_LINES, 32'h14);
      rchk(`LMS_REG_LINES, 32'h10, "lines");
      wr(`LMS_REG_GAIN, 32'hff0010);
      for (int c = 0; c < 8; c++) begin
         wr(`LMS_REG_BRIGHT, 32'(c));
         repeat (3) @(posedge clk_i);
         chk("red", 32'(17 * (c + 1)), {20'h0, cur_r});
         chk("green", 32'(c + 1), {20'h0, cur_g});
         chk("blue", 32'(256 * (c + 1)), {20'h0, cur_b});
      end
      wr(`LMS_REG_IRQEN, 32'h1f);
      for (int m = 0; m < 8; m++) begin
         word = 16'(16'h1234 + m * 16'h1111);
         wr(`LMS_REG_CTRL, 32'h0);
         // reverse bit on odd modes, as on a rotated device
         wr(`LMS_REG_CTRL, 32'(1 + m * 2 + (m % 2) * 16));
         gs_base = gs_cnt;
         hit = 1'b0;
         fork
            ctrl.send_word(word);
            begin
               for (int k = 0; k < 600 && !hit; k++) begin
                  @(posedge clk_i);
                  #1 hit = (en !== 16'h0);
                  en_seen = en;
                  idx_seen = idx;
               end
               @(posedge clk_i);
               flt <= 3'(3'h1 << (m % 3));
               repeat (5) @(posedge clk_i);
               flt <= 3'h0;
            end
         join
         if (!hit) begin
            n_mismatch++;
            close_out;
         end
         repeat (10) @(posedge clk_i);
         chk("enable", m % 2 ? 32'h8000 : 32'h1, {16'h0, en_seen});
         chk("index", m % 2 ? 32'hf : 32'h0, {28'h0, idx_seen});
         chk("ticks", 32'd16, 32'(gs_cnt - gs_base));
         rchk(`LMS_REG_RXWORD, {16'h0, word}, "rxword");
         // serial out trails by one word: last bit shows the previous word's lsb
         chk("serial out", 32'(m > 0 && m % 2 == 0), {31'h0, sdo});
         chk("irq", 32'h1, {31'h0, irq_o});
         rchk(`LMS_REG_STATUS, 32'h1 | (32'h4 << (m % 3)), "status");
         wr(`LMS_REG_CLEAR, 32'h1f);
         rchk(`LMS_REG_STATUS, 32'h0, "status");
         chk("irq", 32'h0, {31'h0, irq_o});
      end
      // fourteen lines: last two switches stay dark, frame ends after line 15
      wr(`LMS_REG_LINES, 32'he);
      wr(`LMS_REG_CTRL, 32'h0);
      wr(`LMS_REG_CTRL, 32'h1);
      for (int j = 0; j < 5; j++)
         ctrl.send_word(16'h00ff);
      repeat (10) @(posedge clk_i);
      chk("lit switches", 32'h3fff, {16'h0, sw_seen});
      rchk(`LMS_REG_STATUS, 32'h3, "status frame");
      // rotated second device of a two-device stack, reverse bit set
      wr(`LMS_REG_CTRL, 32'h0);
      wr(`LMS_REG_CTRL, 32'h33);
      for (int j = 0; j < 5; j++)
         ctrl.send_word(16'h00ff);
      chk("second device dark", 32'h0, {16'h0, sw_seen});
      for (int j = 0; j < 5; j++)
         ctrl.send_word(16'h00ff);
      repeat (10) @(posedge clk_i);
      chk("second device lines", 32'hfffc, {16'h0, sw_seen});
      close_out;
   end
endmodule
bind lms_scan lms_scan_assertions chk_scan (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .serial_data_out_o(serial_data_out_o), .line_enable_o(line_enable_o),
   .line_switch_index_o(line_switch_index_o), .display_row_o(display_row_o),
   .grayscale_clock_o(grayscale_clock_o), .current_red_o(current_red_o));
`default_nettype wire
